// ---- rtl/fdr_regs.sv ----
// drive output, tape, rate and second status registers of the floppy controller
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - enhanced mode second status reads one on bits 6 and 7.
// - alternate status bit 2 sets on write gate rise, clears on input read.
// - alternate status bit 3 sets on read_data_n rise, clears on input read.
// - alternate status bit 4 sets on write_data_n rise, ungated, clears likewise.
// - alternate bits 5,6 show low selects; bits 0,1 read one.
// - output control writable anytime, kept on soft reset, zero on system reset.
// - output control bits 1:0 select one drive in binary.
// - bit 2 low holds controller reset; other registers stay unchanged.
// - soft reset pulse lasts at least 100 ns; back-to-back writes valid.
// - basic/alternate modes: bit 3 gates dma and interrupt, resets zero.
// - enhanced mode: dma and interrupt always enabled, bit 3 resets zero.
// - bits 4 and 5 drive motor outputs; bits 6,7 unsupported.
// - normal decode selects drive with its motor bit set.
// - swapped decode exchanges drives zero and one, selects and motors.
// - tape bits 1:0 assign tape to drive 1..3, never drive 0.
// - tape register survives the soft reset.
// - normal layout tape register reads zero on bits 7:2.
// - enhanced layout returns drive type pair and boot drive.
// - rate register write-only; last write of it or config rate wins.
// - rate register ignores soft reset; system reset loads 02h.
// - rate bits 4:2 choose write precompensation delay.
// - rate bit 7 resets controller and clears itself.
// - rate bit 6 enters low power until soft reset or data/status access.
// - precompensation codes map to fixed delays; 000 is default.
module fdr_regs
  import fdr_pkg::*;
#(
  parameter int SWRST_CYC = FDR_SWRST_CYC
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [9:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic [1:0] sys_mode,
  input wire logic swap_drives,
  input wire logic tape_enhanced,
  input wire logic [7:0] drive_type_config,
  input wire logic [1:0] boot_drive,
  input wire logic cfg_rate_wr,
  input wire logic [1:0] cfg_rate_data,
  input wire logic write_gate,
  input wire logic read_data_n,
  input wire logic write_data_n,
  output logic drive_select_zero_n,
  output logic drive_select_one_n,
  output logic motor_zero_n,
  output logic motor_one_n,
  output logic dma_irq_gate,
  output logic ctrl_reset,
  output logic low_power,
  output logic [1:0] rate_code,
  output logic [2:0] precomp_code,
  output logic [11:0] precomp_tenths,
  output logic [1:0] tape_drive
);
  logic [7:0] outctl_r;
  logic [1:0] tape_r;
  logic [1:0] rate_r;
  logic [2:0] pre_r;
  logic lowpwr_r;
  logic [7:0] swcnt_r;
  logic [2:0] flag_r;
  logic ds0_n_r;
  logic ds1_n_r;
  logic mot0_n_r;
  logic mot1_n_r;
  logic gate_r;
  logic crst_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [11:0] tenths_r;
  logic [2:0] s_rise;
  logic wr_oc;
  logic wr_rate;
  logic rd_dir;
  logic ds0_nxt;
  logic ds1_nxt;
  logic sel0;
  logic sel1;
  fdr_mode_e mode;

  assign mode = fdr_mode_e'(sys_mode);
  assign wr_oc = io_wr && io_addr == FDR_ADDR_OUTCTL;
  assign wr_rate = io_wr && io_addr == FDR_ADDR_RATE;
  assign rd_dir = io_rd && io_addr == FDR_ADDR_DIGIN;

  // ------------------------------------------------------------
  // drive pin synchronisers
  // ------------------------------------------------------------
  fdr_sync_edge #(.WIDTH(3), .IDLE(3'h6)) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .async_in({write_data_n, read_data_n, write_gate}),
    .level(),
    .rise(s_rise),
    .fall()
  );

  // ------------------------------------------------------------
  // output control register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      outctl_r <= FDR_OUTCTL_RST;
    else if (wr_oc)
      outctl_r <= io_wdata;
  end

  // ------------------------------------------------------------
  // tape assign register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      tape_r <= FDR_TAPE_RST;
    else if (io_wr && io_addr == FDR_ADDR_TAPE)
      tape_r <= io_wdata[1:0];
  end

  // ------------------------------------------------------------
  // rate and precompensation select
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rate_r <= FDR_RATE_RST[1:0];
      pre_r <= FDR_RATE_RST[4:2];
      tenths_r <= fdr_precomp_tenths(FDR_RATE_RST[4:2]);
    end
    else if (wr_rate)
    begin
      rate_r <= io_wdata[1:0];
      pre_r <= io_wdata[4:2];
      tenths_r <= fdr_precomp_tenths(io_wdata[4:2]);
    end
    else if (cfg_rate_wr)
      rate_r <= cfg_rate_data;
  end

  // low power: exits on soft reset or data/status access
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      lowpwr_r <= 1'b0;
    else if (crst_r || ((io_rd || io_wr) &&
             (io_addr == FDR_ADDR_DATA || io_addr == FDR_ADDR_RATE) &&
             !(wr_rate && io_wdata[FDR_RS_LOWPWR])))
      lowpwr_r <= 1'b0;
    else if (wr_rate && io_wdata[FDR_RS_LOWPWR])
      lowpwr_r <= 1'b1;
  end

  // ------------------------------------------------------------
  // controller software reset
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      swcnt_r <= '0;
    else if ((wr_rate && io_wdata[FDR_RS_SWRST]) ||
             (wr_oc && !io_wdata[FDR_OC_RST_N]))
      swcnt_r <= 8'(SWRST_CYC);
    else if (swcnt_r != '0)
      swcnt_r <= swcnt_r - 8'h01;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      crst_r <= 1'b1;
    else
      crst_r <= !outctl_r[FDR_OC_RST_N] || swcnt_r != '0 ||
                (wr_rate && io_wdata[FDR_RS_SWRST]) ||
                (wr_oc && !io_wdata[FDR_OC_RST_N]);
  end

  // ------------------------------------------------------------
  // drive and motor decode
  // ------------------------------------------------------------
  assign sel0 = outctl_r[1:0] == 2'h0 && outctl_r[FDR_OC_MOT0];
  assign sel1 = outctl_r[1:0] == 2'h1 && outctl_r[FDR_OC_MOT1];
  assign ds0_nxt = swap_drives ? !sel1 : !sel0;
  assign ds1_nxt = swap_drives ? !sel0 : !sel1;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ds0_n_r <= 1'b1;
      ds1_n_r <= 1'b1;
      mot0_n_r <= 1'b1;
      mot1_n_r <= 1'b1;
    end
    else
    begin
      ds0_n_r <= ds0_nxt;
      ds1_n_r <= ds1_nxt;
      mot0_n_r <= swap_drives ? !outctl_r[FDR_OC_MOT1] :
                  !outctl_r[FDR_OC_MOT0];
      mot1_n_r <= swap_drives ? !outctl_r[FDR_OC_MOT0] :
                  !outctl_r[FDR_OC_MOT1];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      gate_r <= 1'b0;
    else
      gate_r <= mode == FDR_MODE_ENH || outctl_r[FDR_OC_GATE];
  end

  // ------------------------------------------------------------
  // latched pin flags, set beats clear
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      flag_r <= '0;
    else
      flag_r <= (rd_dir ? 3'h0 : flag_r) |
                s_rise;
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = '0;
    case (io_addr)
      FDR_ADDR_STATUS2:
      begin
        if (mode == FDR_MODE_ENH)
          rdata_nxt = FDR_STAT2_ENH | {6'h00, !mot1_n_r, !mot0_n_r};
        else
        begin
          rdata_nxt = FDR_STAT2_BASIC;
          rdata_nxt[FDR_S2_WRITE_GATE] = flag_r[0];
          rdata_nxt[FDR_S2_RDATA] = flag_r[1];
          rdata_nxt[FDR_S2_WDATA] = flag_r[2];
          rdata_nxt[FDR_S2_DS0] = ds0_n_r;
          rdata_nxt[FDR_S2_DS1] = ds1_n_r;
          rdata_nxt[7] = 1'b1;
        end
      end
      FDR_ADDR_OUTCTL: rdata_nxt = outctl_r;
      FDR_ADDR_TAPE:
      begin
        if (tape_enhanced)
          rdata_nxt = {2'h0, drive_type_config[{outctl_r[1:0], 1'b1}],
                       drive_type_config[{outctl_r[1:0], 1'b0}],
                       boot_drive, tape_r};
        else
          rdata_nxt = {6'h00, tape_r};
      end
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_r <= '0;
    else if (io_rd)
      rdata_r <= rdata_nxt;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign io_rdata = rdata_r;
  assign drive_select_zero_n = ds0_n_r;
  assign drive_select_one_n = ds1_n_r;
  assign motor_zero_n = mot0_n_r;
  assign motor_one_n = mot1_n_r;
  assign dma_irq_gate = gate_r;
  assign ctrl_reset = crst_r;
  assign low_power = lowpwr_r;
  assign rate_code = rate_r;
  assign precomp_code = pre_r;
  assign precomp_tenths = tenths_r;
  assign tape_drive = tape_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_swrst_width: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_rate && io_wdata[FDR_RS_SWRST] |=> ctrl_reset [*2])
    else $error("soft reset pulse too short");
  a_oc_rst_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_oc && !io_wdata[FDR_OC_RST_N] ##1 !wr_oc |=> ctrl_reset)
    else $error("reset bit low not holding controller");
  a_one_select: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !(!drive_select_zero_n && !drive_select_one_n))
    else $error("two drives selected");
  a_oc_write: assert property (@(posedge ref_clk) disable iff (!arst_n)
    wr_oc |=> outctl_r == $past(io_wdata))
    else $error("output control write lost");
  a_gate_enh: assert property (@(posedge ref_clk) disable iff (!arst_n)
    mode == FDR_MODE_ENH ##1 mode == FDR_MODE_ENH |-> dma_irq_gate)
    else $error("gate off in enhanced mode");
  a_gate_basic: assert property (@(posedge ref_clk) disable iff (!arst_n)
    mode != FDR_MODE_ENH && !outctl_r[FDR_OC_GATE] |=> !dma_irq_gate)
    else $error("gate on while disabled");
  a_write_gate_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_rise[0] |=> flag_r[0])
    else $error("write gate flag not latched");
  a_flag_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rd_dir && s_rise[1] == 1'b0 |=> !flag_r[1])
    else $error("read data flag not cleared");
  a_rate_cfg: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cfg_rate_wr && !wr_rate |=> rate_code == $past(cfg_rate_data))
    else $error("config rate write lost");
  a_sel_motor: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !swap_drives && outctl_r[1:0] == 2'h0 && !outctl_r[FDR_OC_MOT0]
    ##1 !swap_drives |-> drive_select_zero_n)
    else $error("drive selected without motor bit");
  c_swrst: cover property (@(posedge ref_clk) disable iff (!arst_n)
    wr_oc && !io_wdata[FDR_OC_RST_N] ##1 wr_oc && io_wdata[FDR_OC_RST_N]);
  c_lowpwr: cover property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(low_power));
  c_swap: cover property (@(posedge ref_clk) disable iff (!arst_n)
    swap_drives && !drive_select_one_n);
endmodule
`default_nettype wire

// ---- rtl/fdr_pkg.sv ----
// package: offsets, field positions, reset values and timing for the drive registers
package fdr_pkg;
  // register addresses on the host i/o port
  localparam logic [9:0] FDR_ADDR_STATUS2 = 10'h3f1;
  localparam logic [9:0] FDR_ADDR_OUTCTL = 10'h3f2;
  localparam logic [9:0] FDR_ADDR_TAPE = 10'h3f3;
  localparam logic [9:0] FDR_ADDR_RATE = 10'h3f4;
  localparam logic [9:0] FDR_ADDR_DATA = 10'h3f5;
  localparam logic [9:0] FDR_ADDR_DIGIN = 10'h3f7;
  // output control field positions
  localparam int FDR_OC_SEL_LO = 0;
  localparam int FDR_OC_RST_N = 2;
  localparam int FDR_OC_GATE = 3;
  localparam int FDR_OC_MOT0 = 4;
  localparam int FDR_OC_MOT1 = 5;
  // rate register field positions
  localparam int FDR_RS_PRE_LO = 2;
  localparam int FDR_RS_LOWPWR = 6;
  localparam int FDR_RS_SWRST = 7;
  // second status field positions
  localparam int FDR_S2_WRITE_GATE = 2;
  localparam int FDR_S2_RDATA = 3;
  localparam int FDR_S2_WDATA = 4;
  localparam int FDR_S2_DS0 = 5;
  localparam int FDR_S2_DS1 = 6;
  // reset values
  localparam logic [7:0] FDR_OUTCTL_RST = 8'h00;
  localparam logic [1:0] FDR_TAPE_RST = 2'h0;
  localparam logic [7:0] FDR_RATE_RST = 8'h02;
  localparam logic [7:0] FDR_STAT2_BASIC = 8'h03;
  localparam logic [7:0] FDR_STAT2_ENH = 8'hc0;
  // software reset pulse least width
  localparam int FDR_CLK_MHZ = 125;
  localparam int FDR_SWRST_MIN_NS = 100;
  localparam int FDR_SWRST_CYC = (FDR_SWRST_MIN_NS * FDR_CLK_MHZ + 999) / 1000;
  // precompensation delay tenths of ns per code, below 2 mbps
  typedef enum logic [1:0] {FDR_MODE_BASIC, FDR_MODE_ALT, FDR_MODE_ENH} fdr_mode_e;
  function automatic logic [11:0] fdr_precomp_tenths(input logic [2:0] code);
    case (code)
      3'h7: fdr_precomp_tenths = 12'h000;
      3'h1: fdr_precomp_tenths = 12'h1a1;
      3'h2: fdr_precomp_tenths = 12'h341;
      3'h3: fdr_precomp_tenths = 12'h4e2;
      3'h4: fdr_precomp_tenths = 12'h683;
      3'h5: fdr_precomp_tenths = 12'h823;
      3'h6: fdr_precomp_tenths = 12'h9c4;
      default: fdr_precomp_tenths = 12'hfff;
    endcase
  endfunction
endpackage

// ---- rtl/fdr_sync_edge.sv ----
// two-flop synchroniser with rise and fall pulses
`timescale 1ns/1ps
`default_nettype none
module fdr_sync_edge #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] last_r;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // idle level at reset, so no false edge follows reset
      meta_r <= IDLE;
      sync_r <= IDLE;
      last_r <= IDLE;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~last_r;
  assign fall = ~sync_r & last_r;
endmodule
`default_nettype wire

// ---- dv/fdr_drive_model.sv ----
// drive-side model: pulses write gate, read data and write data pins
`timescale 1ns/1ps
`default_nettype none
module fdr_drive_model (
  input wire logic ref_clk,
  input wire logic [2:0] pulse_req,
  output logic write_gate,
  output logic read_data_n,
  output logic write_data_n
);
  // ----------------------------------------
  // pulse length counters, one per pin
  // ----------------------------------------
  logic [2:0] cnt_r [3];
  initial
  begin
    cnt_r = '{3'h0, 3'h0, 3'h0};
  end
  always @(posedge ref_clk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (pulse_req[i])
        cnt_r[i] <= 3'h4;
      else if (cnt_r[i] != 3'h0)
        cnt_r[i] <= cnt_r[i] - 3'h1;
    end
  end
  // pins change off the clock edge, as async drive lines do
  assign #3 write_gate = (cnt_r[0] != 3'h0);
  assign #3 read_data_n = (cnt_r[1] == 3'h0);
  assign #3 write_data_n = (cnt_r[2] == 3'h0);
endmodule
`default_nettype wire

// ---- dv/floppy_drive_control_registers_bench.sv ----
// self-checking bench for the drive control registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) \
    begin \
      bad_count++; \
      $display("BAD %s exp %h got %h", nm, ex, got); \
    end \
  end
module floppy_drive_control_registers_bench;
  import fdr_pkg::*;
  localparam int SW = FDR_SWRST_CYC;
  logic ref_clk = 0, arst_n = 0, io_wr = 0, io_rd = 0;
  logic swap_drives = 0, tape_enhanced = 0, cfg_rate_wr = 0;
  logic [9:0] io_addr = 10'h000;
  logic [7:0] io_wdata = 8'h00, drive_type_config = 8'he4, io_rdata, d;
  logic [1:0] sys_mode = 2'h0, boot_drive = 2'h2, cfg_rate_data = 2'h3;
  logic [2:0] pulse_req = 3'h0, precomp_code;
  logic write_gate, read_data_n, write_data_n, dma_irq_gate, ctrl_reset;
  logic drive_select_zero_n, drive_select_one_n, motor_zero_n, motor_one_n;
  logic low_power;
  logic [1:0] rate_code, tape_drive;
  logic [11:0] precomp_tenths;
  logic [11:0] tenths [8] = '{12'hfff, 12'h1a1, 12'h341, 12'h4e2,
    12'h683, 12'h823, 12'h9c4, 12'h000};
  int bad_count = 0, cmp_count = 0, n;

  fdr_regs #(.SWRST_CYC(SW)) i_fdr_regs (.ref_clk(ref_clk), .arst_n(arst_n),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .sys_mode(sys_mode), .swap_drives(swap_drives),
    .tape_enhanced(tape_enhanced), .drive_type_config(drive_type_config),
    .boot_drive(boot_drive), .cfg_rate_wr(cfg_rate_wr),
    .cfg_rate_data(cfg_rate_data), .write_gate(write_gate),
    .read_data_n(read_data_n), .write_data_n(write_data_n),
    .drive_select_zero_n(drive_select_zero_n),
    .drive_select_one_n(drive_select_one_n), .motor_zero_n(motor_zero_n),
    .motor_one_n(motor_one_n), .dma_irq_gate(dma_irq_gate),
    .ctrl_reset(ctrl_reset), .low_power(low_power), .rate_code(rate_code),
    .precomp_code(precomp_code), .precomp_tenths(precomp_tenths),
    .tape_drive(tape_drive));
  fdr_drive_model i_fdr_drive_model (.ref_clk(ref_clk),
    .pulse_req(pulse_req), .write_gate(write_gate),
    .read_data_n(read_data_n), .write_data_n(write_data_n));

  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    io_addr = a;
    io_wdata = v;
    io_wr = 1;
    step(1);
    io_wr = 0;
    step(1);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] ex,
    input logic [7:0] m);
    io_addr = a;
    io_rd = 1;
    step(1);
    io_rd = 0;
    step(1);
    `CHK("io_rdata", ex & m, io_rdata & m)
  endtask
  task automatic pins(input logic [3:0] ex);
    `CHK("sel_mot", ex, {drive_select_one_n, drive_select_zero_n,
      motor_one_n, motor_zero_n})
  endtask
  task automatic rst_len();
    while (ctrl_reset === 1'b1 && n < 60)
    begin
      n++;
      step(1);
    end
    if (n == 60)
    begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    step(4);
    arst_n = 1;
    step(1);
    `CHK("rst", 4'ha, {ctrl_reset, dma_irq_gate, rate_code})
    `CHK("precomp", 3'h0, precomp_code)
    pins(4'hf);
    rd(FDR_ADDR_OUTCTL, 8'h00, 8'hff);
    rd(FDR_ADDR_TAPE, 8'h00, 8'hff);
    wr(FDR_ADDR_OUTCTL, 8'h1c);
    pins(4'ha);
    `CHK("gate_rst", 2'h2, {dma_irq_gate, ctrl_reset})
    wr(FDR_ADDR_OUTCTL, 8'h2d);
    pins(4'h5);
    rd(FDR_ADDR_OUTCTL, 8'h2d, 8'hff);
    io_addr = FDR_ADDR_OUTCTL;
    io_wdata = 8'h29;
    io_wr = 1;
    step(1);
    n = (ctrl_reset === 1'b1) ? 1 : 0;
    io_wdata = 8'h2d;
    step(1);
    io_wr = 0;
    rst_len();
    `CHK("soft_reset_low_width", 1'b1, n * 8 >= FDR_SWRST_MIN_NS)
    pins(4'h5);
    sys_mode = 2'h2;
    wr(FDR_ADDR_OUTCTL, 8'h24);
    `CHK("enh_gate", 1'b1, dma_irq_gate)
    pins(4'hd);
    sys_mode = 2'h0;
    step(2);
    `CHK("basic_gate", 1'b0, dma_irq_gate)
    swap_drives = 1;
    wr(FDR_ADDR_OUTCTL, 8'h1c);
    pins(4'h5);
    swap_drives = 0;
    wr(FDR_ADDR_OUTCTL, 8'h2d);
    for (int c = 0; c < 4; c++)
    begin
      wr(FDR_ADDR_TAPE, {6'h3f, c[1:0]});
      rd(FDR_ADDR_TAPE, {6'h00, c[1:0]}, 8'hff);
      `CHK("tape_drive", c[1:0], tape_drive)
    end
    tape_enhanced = 1;
    step(2);
    rd(FDR_ADDR_TAPE, 8'h1b, 8'h3f);
    tape_enhanced = 0;
    for (int c = 0; c < 8; c++)
    begin
      wr(FDR_ADDR_RATE, {3'h0, c[2:0], 2'h1});
      `CHK("precomp", {c[2:0], 2'h1}, {precomp_code, rate_code})
      `CHK("tenths", tenths[c], precomp_tenths)
    end
    cfg_rate_wr = 1;
    step(1);
    cfg_rate_wr = 0;
    step(2);
    `CHK("cfg_rate", 2'h3, rate_code)
    wr(FDR_ADDR_RATE, 8'h8a);
    n = 1;
    rst_len();
    `CHK("swrst_len", 1'b1, n >= SW + 1)
    `CHK("swrst_ns", 1'b1, n * 8 >= FDR_SWRST_MIN_NS)
    `CHK("rate_kept", 5'h0a, {precomp_code, rate_code})
    `CHK("tape_kept", 2'h3, tape_drive)
    rd(FDR_ADDR_OUTCTL, 8'h2d, 8'hff);
    wr(FDR_ADDR_RATE, 8'h42);
    `CHK("low_power", 1'b1, low_power)
    rd(FDR_ADDR_DATA, 8'h00, 8'h00);
    step(1);
    `CHK("low_power", 1'b0, low_power)
    sys_mode = 2'h1;
    rd(FDR_ADDR_DIGIN, 8'h00, 8'h00);
    rd(FDR_ADDR_STATUS2, 8'ha3, 8'hff);
    pulse_req = 3'h7;
    step(1);
    pulse_req = 3'h0;
    step(12);
    rd(FDR_ADDR_STATUS2, 8'hbf, 8'hff);
    rd(FDR_ADDR_DIGIN, 8'h00, 8'h00);
    rd(FDR_ADDR_STATUS2, 8'ha3, 8'hff);
    sys_mode = 2'h2;
    step(2);
    rd(FDR_ADDR_STATUS2, 8'hc0, 8'hc0);
    final_report();
  end
endmodule
`default_nettype wire
